// ### rtl/turn_on_sequencer.sv
// Purpose: turn-on sequencing, power-good and turn-on timeout fault response
// Assumes: reset_i also stands for loss of bias power
// Notes: voltages compared as unsigned codes in output-voltage format
// What this block does
// - 16-bit assert threshold; output-ok asserts once output reaches it.
// - below 16-bit negate threshold: drop output-ok if enabled, set status bit.
// - wait the 16-bit turn-on delay in ms after enable before rising.
// - ramp the output over the 16-bit rise time after the delay.
// - turn-on fault if undervoltage limit not reached within the timeout.
// - timeout value zero disables the turn-on fault check.
// - response byte: 7:6 response, 5:3 retries, 2:0 delay count.
// - response 00 ignores the fault and keeps running.
// - response 01 runs for the delay, then applies retries if still faulty.
// - response 10 disables output at once, then applies retries.
// - clear by status clear, clear-all command, reset, or off-then-on.
// - removal of bias power clears a latched turn-on fault.
// - retry setting 000 never restarts; output stays off until cleared.
// - retry settings 001 to 101 restart one to five times.
// - once all restarts fail, output stays off until cleared.
// - restarts spaced by delay count times the fault time unit.
// - delay code n selects 2**n units; unit given from outside.
// - retry setting 111 retries until commanded off or reset.
`timescale 1ns/1ps
`default_nettype none
module turn_on_sequencer #(
  parameter int MS_CYCLES = seq_pkg::MS_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic wr_stb_i,
  input wire logic [15:0] wr_data_i,
  input wire logic rd_stb_i,
  output logic [15:0] rd_data_o,
  input wire logic enable_i,
  input wire logic clear_faults_i,
  input wire logic clear_fault_bit_i,
  input wire logic clear_pg_bit_i,
  input wire logic pg_pin_enable_i,
  input wire logic [7:0] fault_unit_ms_i,
  input wire logic [15:0] vout_i,
  input wire logic [15:0] uv_limit_i,
  output logic output_ok_signal_o,
  output logic pg_status_o,
  output logic ton_fault_o,
  output logic output_enable_o,
  output logic ramp_active_o
);
  ////////////////////////////////////////////////////////////////////////
  seq_timer_if tif ();

  ms_tick_gen #(.MS_CYCLES(MS_CYCLES)) u_tick (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .tif(tif.tick_src)
  );

  phase_timer u_timer (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .tif(tif.timer)
  );

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] pg_on_q, pg_off_q, ton_dly_q, turn_on_rise_time_q, ton_lim_q;
  logic [7:0] ton_resp_q;
  logic [15:0] rd_mux;

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      pg_on_q <= seq_pkg::RST_PG_ASSERT;
      pg_off_q <= seq_pkg::RST_PG_NEGATE;
      ton_dly_q <= seq_pkg::RST_TURN_ON_DELAY_TIME;
      turn_on_rise_time_q <= seq_pkg::RST_TURN_ON_RISE_TIME;
      ton_lim_q <= seq_pkg::RST_TON_LIMIT;
      ton_resp_q <= seq_pkg::RST_TON_RESP;
    end
    else if (wr_stb_i)
    begin
      unique case (cmd_code_i)
        seq_pkg::CMD_PG_ASSERT: pg_on_q <= wr_data_i;
        seq_pkg::CMD_PG_NEGATE: pg_off_q <= wr_data_i;
        seq_pkg::CMD_TURN_ON_DELAY_TIME: ton_dly_q <= wr_data_i;
        seq_pkg::CMD_TURN_ON_RISE_TIME: turn_on_rise_time_q <= wr_data_i;
        seq_pkg::CMD_TON_LIMIT: ton_lim_q <= wr_data_i;
        seq_pkg::CMD_TON_RESP: ton_resp_q <= wr_data_i[7:0];
        default: ;
      endcase
    end
  end

  // unmapped codes read as zero
  assign rd_mux =
    (cmd_code_i == seq_pkg::CMD_PG_ASSERT) ? pg_on_q :
    (cmd_code_i == seq_pkg::CMD_PG_NEGATE) ? pg_off_q :
    (cmd_code_i == seq_pkg::CMD_TURN_ON_DELAY_TIME) ? ton_dly_q :
    (cmd_code_i == seq_pkg::CMD_TURN_ON_RISE_TIME) ? turn_on_rise_time_q :
    (cmd_code_i == seq_pkg::CMD_TON_LIMIT) ? ton_lim_q :
    (cmd_code_i == seq_pkg::CMD_TON_RESP) ? {8'h00, ton_resp_q} : 16'h0000;

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
      rd_data_o <= '0;
    else if (rd_stb_i)
      rd_data_o <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////
  // response field decode
  logic [1:0] resp;
  logic [2:0] retry_set;
  logic [2:0] dly_code;
  logic [15:0] fault_wait_ms;

  assign resp = ton_resp_q[seq_pkg::RESP_MSB:seq_pkg::RESP_LSB];
  assign retry_set = ton_resp_q[seq_pkg::RETRY_MSB:seq_pkg::RETRY_LSB];
  assign dly_code = ton_resp_q[seq_pkg::DLY_MSB:seq_pkg::DLY_LSB];
  // 8x8 product fits 16 bits, no saturation needed
  assign fault_wait_ms = 16'(fault_unit_ms_i) * 16'(seq_pkg::delay_units(dly_code));

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  seq_pkg::seq_state_e state_q, state_d;
  logic [2:0] tries_q, tries_d;
  logic [15:0] to_cnt_q;
  logic reached_q, timed_q, fault_evt, reached_now;
  logic any_clear, retry_ok, still_low;

  assign any_clear = clear_faults_i || clear_fault_bit_i;
  assign still_low = (vout_i < uv_limit_i);
  assign reached_now = !still_low && (state_q == seq_pkg::ST_RISE ||
                                      state_q == seq_pkg::ST_ON);
  assign retry_ok = (retry_set == seq_pkg::RETRY_FOREVER) ||
                    (retry_set != seq_pkg::RETRY_NONE && tries_q != 3'h0);
  // timeout counts from start of delay until the output reaches uv level
  assign fault_evt = tif.ms_tick && !reached_q && !timed_q &&
                     (ton_lim_q != 16'h0000) &&
                     (to_cnt_q + 16'h0001 >= ton_lim_q) &&
                     (state_q == seq_pkg::ST_DELAY || state_q == seq_pkg::ST_RISE ||
                      state_q == seq_pkg::ST_ON);

  always_comb
  begin
    state_d = state_q;
    tries_d = tries_q;
    tif.start = 1'b0;
    tif.load = '0;
    unique case (state_q)
      seq_pkg::ST_OFF:
        if (enable_i)
        begin
          state_d = seq_pkg::ST_DELAY;
          tif.start = 1'b1;
          tif.load = ton_dly_q;
        end
      seq_pkg::ST_DELAY:
        if (tif.expire)
        begin
          state_d = seq_pkg::ST_RISE;
          tif.start = 1'b1;
          tif.load = turn_on_rise_time_q;
        end
      seq_pkg::ST_RISE:
        if (tif.expire)
          state_d = seq_pkg::ST_ON;
      seq_pkg::ST_ON: ;
      seq_pkg::ST_HOLD:
        if (tif.expire)
          state_d = still_low ? seq_pkg::ST_RETRY_WAIT : seq_pkg::ST_ON;
      seq_pkg::ST_RETRY_WAIT:
        if (tif.expire)
        begin
          state_d = seq_pkg::ST_DELAY;
          tif.start = 1'b1;
          tif.load = ton_dly_q;
        end
      seq_pkg::ST_LATCHED:
        if (any_clear)
          state_d = seq_pkg::ST_OFF;
    endcase
    // decide on a restart once the hold window ends with the output still low
    if (state_d == seq_pkg::ST_RETRY_WAIT && state_q == seq_pkg::ST_HOLD)
    begin
      if (retry_ok)
      begin
        tif.start = 1'b1;
        tif.load = fault_wait_ms;
        if (retry_set != seq_pkg::RETRY_FOREVER)
          tries_d = tries_q - 3'h1;
      end
      else
        state_d = seq_pkg::ST_LATCHED;
    end
    if (fault_evt)
    begin
      unique case (resp)
        seq_pkg::RESP_IGNORE: ;
        seq_pkg::RESP_HOLD:
        begin
          state_d = seq_pkg::ST_HOLD;
          tif.start = 1'b1;
          tif.load = fault_wait_ms;
        end
        seq_pkg::RESP_DISABLE:
          if (retry_ok)
          begin
            state_d = seq_pkg::ST_RETRY_WAIT;
            tif.start = 1'b1;
            tif.load = fault_wait_ms;
            if (retry_set != seq_pkg::RETRY_FOREVER)
              tries_d = tries_q - 3'h1;
          end
          else
            state_d = seq_pkg::ST_LATCHED;
        seq_pkg::RESP_LATCH: state_d = seq_pkg::ST_LATCHED;
      endcase
    end
    if (reached_now || any_clear || !enable_i)
      tries_d = retry_set;
    // off clears any latched state; on again restarts
    if (!enable_i)
      state_d = seq_pkg::ST_OFF;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      state_q <= seq_pkg::ST_OFF;
      tries_q <= seq_pkg::RETRY_NONE;
    end
    else
    begin
      state_q <= state_d;
      tries_q <= tries_d;
    end
  end

  // new attempt restarts the timeout window
  logic attempt_start;
  assign attempt_start = state_d == seq_pkg::ST_DELAY && state_q != seq_pkg::ST_DELAY;

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i || attempt_start)
    begin
      to_cnt_q <= '0;
      reached_q <= 1'b0;
      timed_q <= 1'b0;
    end
    else
    begin
      if (tif.ms_tick && to_cnt_q != 16'hFFFF)
        to_cnt_q <= to_cnt_q + 16'h0001;
      if (reached_now)
        reached_q <= 1'b1;
      if (fault_evt)
        timed_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status and power-good; hardware set wins over clear
  logic ton_fault_q, pg_q, pg_stat_q, running;

  assign running = state_q == seq_pkg::ST_ON || state_q == seq_pkg::ST_HOLD;

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      ton_fault_q <= 1'b0;
      pg_q <= 1'b0;
      pg_stat_q <= 1'b0;
    end
    else
    begin
      ton_fault_q <= fault_evt || (ton_fault_q && !any_clear);
      if (!running || vout_i < pg_off_q)
        pg_q <= 1'b0;
      else if (vout_i >= pg_on_q)
        pg_q <= 1'b1;
      pg_stat_q <= (running && vout_i < pg_off_q) ||
                   (pg_stat_q && !(clear_faults_i || clear_pg_bit_i));
    end
  end

  // pin only follows when the pin setup enables it
  assign output_ok_signal_o = pg_q && pg_pin_enable_i;
  assign pg_status_o = pg_stat_q;
  assign ton_fault_o = ton_fault_q;
  assign output_enable_o = state_q == seq_pkg::ST_RISE || running;
  assign ramp_active_o = state_q == seq_pkg::ST_RISE;

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_fault_disable;
    fault_evt && resp == seq_pkg::RESP_DISABLE;
  endsequence

  chk_pg_assert_level: assert property (
    running && vout_i >= pg_on_q && vout_i >= pg_off_q
    && state_d == state_q |=> output_ok_signal_o == pg_pin_enable_i)
    else $error("power ok not asserted above threshold");
  chk_pg_negate_status: assert property (
    running && vout_i < pg_off_q |=> pg_status_o && !output_ok_signal_o)
    else $error("negate threshold missed");
  chk_delay_to_rise: assert property (
    state_q == seq_pkg::ST_DELAY && tif.expire && enable_i && !fault_evt
    |=> ramp_active_o)
    else $error("rise did not follow turn-on delay");
  chk_timeout_zero: assert property (
    ton_lim_q == 16'h0000 |-> !fault_evt)
    else $error("fault with timeout disabled");
  chk_ignore_runs: assert property (
    fault_evt && resp == seq_pkg::RESP_IGNORE && enable_i
    |=> ton_fault_o && state_q == $past(state_d))
    else $error("ignored fault disturbed sequencing");
  chk_disable_now: assert property (
    s_fault_disable |=> !output_enable_o && ton_fault_o)
    else $error("output not disabled on fault");
  chk_latch_holds: assert property (
    state_q == seq_pkg::ST_LATCHED && !any_clear && enable_i
    |=> !output_enable_o [*2] or ##1 any_clear || !enable_i)
    else $error("latched output came back");
  chk_no_retry: assert property (
    s_fault_disable and (retry_set == seq_pkg::RETRY_NONE && enable_i)
    |=> state_q == seq_pkg::ST_LATCHED)
    else $error("restart with retries off");
  chk_clear_latch: assert property (
    state_q == seq_pkg::ST_LATCHED && any_clear |=> state_q == seq_pkg::ST_OFF)
    else $error("clear did not release latch");
endmodule
`default_nettype wire

// ### inc/seq_pkg.sv
// Purpose: constants for the turn-on sequencer and its fault response
// Assumes: 125 MHz core clock, millisecond timing base
// Notes: command codes double as register addresses
package seq_pkg;
  localparam logic [7:0] CMD_PG_ASSERT = 8'h5E;
  localparam logic [7:0] CMD_PG_NEGATE = 8'h5F;
  localparam logic [7:0] CMD_TURN_ON_DELAY_TIME = 8'h60;
  localparam logic [7:0] CMD_TURN_ON_RISE_TIME = 8'h61;
  localparam logic [7:0] CMD_TON_LIMIT = 8'h62;
  localparam logic [7:0] CMD_TON_RESP = 8'h63;
  localparam logic [15:0] RST_PG_ASSERT = 16'h0000;
  localparam logic [15:0] RST_PG_NEGATE = 16'h0000;
  localparam logic [15:0] RST_TURN_ON_DELAY_TIME = 16'h0000;
  localparam logic [15:0] RST_TURN_ON_RISE_TIME = 16'h0000;
  localparam logic [15:0] RST_TON_LIMIT = 16'h0000;
  localparam logic [7:0] RST_TON_RESP = 8'h00;
  localparam int RESP_MSB = 7;
  localparam int RESP_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DLY_MSB = 2;
  localparam int DLY_LSB = 0;
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_HOLD = 2'h1;
  localparam logic [1:0] RESP_DISABLE = 2'h2;
  localparam logic [1:0] RESP_LATCH = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int MS_CNT_W = 17;
  localparam int TMR_W = 16;

  typedef enum logic [2:0] {
    ST_OFF, ST_DELAY, ST_RISE, ST_ON, ST_HOLD, ST_RETRY_WAIT, ST_LATCHED
  } seq_state_e;

  // delay field code n selects 2**n time units
  function automatic logic [7:0] delay_units(input logic [2:0] code);
    delay_units = 8'h01 << code;
  endfunction
endpackage

// ### inc/seq_timer_if.sv
// Purpose: carries the millisecond tick and phase timer handshake
// Assumes: single core clock domain
// Notes: start and expire are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface seq_timer_if;
  logic ms_tick;
  logic start;
  logic [seq_pkg::TMR_W-1:0] load;
  logic expire;
  logic busy;
  modport tick_src (output ms_tick);
  modport timer (input ms_tick, input start, input load, output expire, output busy);
  modport ctrl (input ms_tick, output start, output load, input expire, input busy);
endinterface
`default_nettype wire

// ### rtl/ms_tick_gen.sv
// Purpose: one-cycle enable pulse every millisecond
// Assumes: free running from reset
// Notes: phase is not aligned to any start request
`timescale 1ns/1ps
`default_nettype none
module ms_tick_gen #(
  parameter int MS_CYCLES = seq_pkg::MS_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  seq_timer_if.tick_src tif
);
  logic [seq_pkg::MS_CNT_W-1:0] cnt_q;
  logic wrap;

  assign wrap = (cnt_q == seq_pkg::MS_CNT_W'(MS_CYCLES - 1));

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
      cnt_q <= '0;
    else
      cnt_q <= wrap ? '0 : cnt_q + 1'b1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
      tif.ms_tick <= 1'b0;
    else
      tif.ms_tick <= wrap;
  end
endmodule
`default_nettype wire

// ### rtl/phase_timer.sv
// Purpose: millisecond down-counter for sequencing phases
// Assumes: load of zero expires on the next tick
// Notes: a new start restarts the count
`timescale 1ns/1ps
`default_nettype none
module phase_timer (
  input wire logic core_clk_i,
  input wire logic reset_i,
  seq_timer_if.timer tif
);
  logic [seq_pkg::TMR_W-1:0] cnt_q;
  logic last;

  assign last = tif.busy && tif.ms_tick && (cnt_q <= seq_pkg::TMR_W'(1));

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      cnt_q <= '0;
      tif.busy <= 1'b0;
      tif.expire <= 1'b0;
    end
    else
    begin
      tif.expire <= last && !tif.start;
      if (tif.start)
      begin
        cnt_q <= tif.load;
        tif.busy <= 1'b1;
      end
      else if (last)
        tif.busy <= 1'b0;
      else if (tif.busy && tif.ms_tick)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### verification/vout_plant.sv
// Purpose: output stage stand-in that makes the measured output voltage
// Assumes: one core clock; ramps only while the output is enabled
// Notes: stuck_i holds the output low to provoke a turn-on fault
`timescale 1ns/1ps
`default_nettype none
module vout_plant (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic drive_i,
  input wire logic stuck_i,
  output logic [15:0] vout_o
);
  ////////////////////////////////////////////////////////////
  // slow ramp, so the thresholds are crossed one after another
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i || !drive_i || stuck_i)
    begin
      vout_o <= 16'h0000;
    end
    else if (vout_o < 16'h0100)
    begin
      vout_o <= vout_o + 16'h0020;
    end
  end
endmodule
`default_nettype wire

// ### verification/test_turn_on_sequencer.sv
// Purpose: self-checking bench for the turn-on sequencer
// Assumes: short millisecond of 8 cycles, fault time unit of 1 ms
// Notes: windows are bounded; the ms tick phase is not controlled
`timescale 1ns/1ps
`default_nettype none
module test_turn_on_sequencer;
  logic core_clk_i, reset_i, wr_stb_i, rd_stb_i, enable_i, stuck;
  logic clear_faults_i, clear_fault_bit_i, clear_pg_bit_i, pg_pin_enable_i;
  logic [7:0] cmd_code_i;
  logic [15:0] wr_data_i;
  wire logic [15:0] rd_data_o;
  wire logic [15:0] vout;
  wire logic output_ok_signal_o, pg_status_o, ton_fault_o, output_enable_o, ramp_active_o;
  int err_count, num_checks, cyc, attempts, n;
  logic oe_prev;
  logic [2:0] retry_tab [0:3];

  turn_on_sequencer #(.MS_CYCLES(8)) i_turn_on_sequencer (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .cmd_code_i(cmd_code_i),
    .wr_stb_i(wr_stb_i), .wr_data_i(wr_data_i), .rd_stb_i(rd_stb_i),
    .rd_data_o(rd_data_o), .enable_i(enable_i), .clear_faults_i(clear_faults_i),
    .clear_fault_bit_i(clear_fault_bit_i), .clear_pg_bit_i(clear_pg_bit_i),
    .pg_pin_enable_i(pg_pin_enable_i), .fault_unit_ms_i(8'h01), .vout_i(vout),
    .uv_limit_i(16'h0080), .output_ok_signal_o(output_ok_signal_o),
    .pg_status_o(pg_status_o), .ton_fault_o(ton_fault_o),
    .output_enable_o(output_enable_o), .ramp_active_o(ramp_active_o));
  vout_plant i_vout_plant (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .drive_i(output_enable_o), .stuck_i(stuck), .vout_o(vout));

  ////////////////////////////////////////////////////////////
  initial
  begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  // counts turn-on attempts on the settled edge; the ceiling cuts a hang short
  always @(negedge core_clk_i)
  begin
    cyc++;
    oe_prev <= output_enable_o;
    if (output_enable_o === 1'b1 && oe_prev === 1'b0)
    begin
      attempts++;
    end
    if (cyc == 20000)
    begin
      err_count++;
      $display("BAD %0t run too long", $time);
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (err_count == 0 && num_checks > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic cycles(input int k);
    repeat (k) @(negedge core_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk_i);
    cmd_code_i = a;
    wr_data_i = d;
    wr_stb_i = 1'b1;
    @(negedge core_clk_i);
    wr_stb_i = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge core_clk_i);
    cmd_code_i = a;
    rd_stb_i = 1'b1;
    @(negedge core_clk_i);
    rd_stb_i = 1'b0;
    chk(rd_data_o, exp, "register read");
  endtask

  // k: 0 clear all, 1 fault bit, 2 pg bit
  task automatic pulse(input int k);
    @(negedge core_clk_i);
    clear_faults_i = (k == 0);
    clear_fault_bit_i = (k == 1);
    clear_pg_bit_i = (k == 2);
    @(negedge core_clk_i);
    clear_faults_i = 1'b0;
    clear_fault_bit_i = 1'b0;
    clear_pg_bit_i = 1'b0;
  endtask

  // k: 0 output enable, 1 turn-on fault; w returns cycles waited
  task automatic wait_sig(input int k, input logic v, input int lim, output int w);
    w = 0;
    while (((k == 0) ? output_enable_o : ton_fault_o) !== v && w < lim)
    begin
      @(negedge core_clk_i);
      w++;
    end
    chk({15'h0000, (k == 0) ? output_enable_o : ton_fault_o}, {15'h0000, v}, "wait");
  endtask

  // off, new response byte, then on with the output held low
  task automatic run_fault(input logic [7:0] resp, input int win);
    enable_i = 1'b0;
    stuck = 1'b1;
    wr(seq_pkg::CMD_TON_RESP, {8'h00, resp});
    // stale fault bit would hide the new one
    pulse(0);
    attempts = 0;
    enable_i = 1'b1;
    cycles(win);
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    cmd_code_i = 8'h00;
    wr_data_i = 16'h0000;
    wr_stb_i = 1'b0;
    rd_stb_i = 1'b0;
    enable_i = 1'b0;
    stuck = 1'b0;
    clear_faults_i = 1'b0;
    clear_fault_bit_i = 1'b0;
    clear_pg_bit_i = 1'b0;
    pg_pin_enable_i = 1'b1;
    retry_tab = '{3'h0, 3'h2, 3'h5, 3'h1};
    reset_i = 1'b1;
    cycles(5);
    reset_i = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      rd(seq_pkg::CMD_PG_ASSERT + i, 16'h0000);
      wr(seq_pkg::CMD_PG_ASSERT + i, 16'hA5C3 + i);
      rd(seq_pkg::CMD_PG_ASSERT + i, (i == 5) ? 16'h00C8 : 16'hA5C3 + i);
    end
    wr(8'h64, 16'h1234);
    rd(8'h64, 16'h0000);
    wr(seq_pkg::CMD_PG_ASSERT, 16'h00C0);
    wr(seq_pkg::CMD_PG_NEGATE, 16'h00A0);
    wr(seq_pkg::CMD_TURN_ON_DELAY_TIME, 16'h0002);
    wr(seq_pkg::CMD_TURN_ON_RISE_TIME, 16'h0001);
    wr(seq_pkg::CMD_TON_LIMIT, 16'h0000);
    wr(seq_pkg::CMD_TON_RESP, 16'h0000);
    // normal power-up
    enable_i = 1'b1;
    cycles(4);
    chk({15'h0000, output_enable_o}, 16'h0000, "early output");
    wait_sig(0, 1'b1, 40, n);
    chk({15'h0000, ramp_active_o}, 16'h0001, "ramp");
    cycles(30);
    chk({15'h0000, ramp_active_o}, 16'h0000, "ramp end");
    chk({15'h0000, output_ok_signal_o}, 16'h0001, "pg on");
    // sag below negate, no timeout limit
    stuck = 1'b1;
    cycles(3);
    chk({14'h0000, output_ok_signal_o, pg_status_o}, 16'h0001, "pg off");
    cycles(100);
    chk({14'h0000, ton_fault_o, output_enable_o}, 16'h0001, "no limit");
    stuck = 1'b0;
    cycles(6);
    pulse(2);
    chk({14'h0000, output_ok_signal_o, pg_status_o}, 16'h0002, "pg back");
    pg_pin_enable_i = 1'b0;
    cycles(1);
    chk({15'h0000, output_ok_signal_o}, 16'h0000, "pin off");
    pg_pin_enable_i = 1'b1;
    // fault responses with a 3 ms limit
    wr(seq_pkg::CMD_TON_LIMIT, 16'h0003);
    run_fault(8'h00, 100);
    chk({14'h0000, ton_fault_o, output_enable_o}, 16'h0003, "ignore");
    run_fault(8'hE8, 150);
    chk({14'h0000, ton_fault_o, output_enable_o}, 16'h0002, "latch");
    chk(attempts[15:0], 16'h0001, "latch attempts");
    pulse(1);
    chk({15'h0000, ton_fault_o}, 16'h0000, "bit clear");
    wait_sig(0, 1'b1, 20, n);
    cycles(150);
    pulse(0);
    chk({15'h0000, ton_fault_o}, 16'h0000, "clear all");
    cycles(150);
    reset_i = 1'b1;
    cycles(2);
    chk({14'h0000, ton_fault_o, output_enable_o}, 16'h0000, "reset");
    reset_i = 1'b0;
    // reset wiped the settings, so load the delay, rise time and limit again
    rd(seq_pkg::CMD_TON_LIMIT, 16'h0000);
    wr(seq_pkg::CMD_TURN_ON_DELAY_TIME, 16'h0002);
    wr(seq_pkg::CMD_TURN_ON_RISE_TIME, 16'h0001);
    wr(seq_pkg::CMD_TON_LIMIT, 16'h0003);
    // restart counts, code 0 spacing
    for (int i = 0; i < 4; i++)
    begin
      run_fault({2'b10, retry_tab[i], 3'b000}, 60 * (retry_tab[i] + 1) + 100);
      chk(attempts[15:0], retry_tab[i] + 16'h0001, "attempts");
      chk({14'h0000, ton_fault_o, output_enable_o}, 16'h0002, "gave up");
    end
    attempts = 0;
    pulse(0);
    cycles(200);
    chk(attempts[15:0], 16'h0002, "reload");
    run_fault(8'hB8, 400);
    chk({15'h0000, attempts >= 8}, 16'h0001, "endless");
    // 4 ms spacing between off and the next try
    run_fault(8'h8A, 0);
    wait_sig(1, 1'b1, 60, n);
    cycles(1);
    wait_sig(0, 1'b1, 80, n);
    chk({15'h0000, n >= 24 && n <= 56}, 16'h0001, "spacing");
    // keep running for 4 ms, then latch
    run_fault(8'h42, 0);
    wait_sig(1, 1'b1, 60, n);
    cycles(16);
    chk({15'h0000, output_enable_o}, 16'h0001, "hold on");
    cycles(60);
    chk({15'h0000, output_enable_o}, 16'h0000, "hold off");
    end_sim();
  end
endmodule
`default_nettype wire
